// *** ctd_defs.svh ***
// constants for the control instruction decoder
`ifndef CTD_DEFS_SVH
`define CTD_DEFS_SVH

// word field positions
`define CTD_OP_HI 15
`define CTD_OP_LO 11
`define CTD_SUB_HI 10
`define CTD_SUB_LO 8
`define CTD_NH_HI 7
`define CTD_NH_LO 4
`define CTD_NL_HI 3
`define CTD_NL_LO 0
`define CTD_ADDR_HI 10
`define CTD_ADDR_LO 0

// widths
`define CTD_WORD_W 16
`define CTD_ADDR_W 11
`define CTD_PAGE_W 2

// major opcodes
`define CTD_OP_CTRL 5'h07
`define CTD_OP_JUMP0 5'h0C
`define CTD_OP_JUMP1 5'h0D
`define CTD_OP_JUMP2 5'h0E
`define CTD_OP_JUMP3 5'h0F
`define CTD_OP_CALL 5'h1C

// sub-codes of the control group
`define CTD_SUB_ALLOW 3'h0
`define CTD_SUB_BLOCK 3'h1
`define CTD_SUB_STOP 3'h2
`define CTD_SUB_HALT 3'h3
`define CTD_SUB_NOP 3'h4

// fixed nibbles
`define CTD_NIB_CTRL 4'hF
`define CTD_NIB_ZERO 4'h0

// page select values
`define CTD_PAGE_0 2'h0
`define CTD_PAGE_1 2'h1
`define CTD_PAGE_2 2'h2
`define CTD_PAGE_3 2'h3

// reset values
`define CTD_INTR_RST 1'b0
`define CTD_PAGE_RST 2'h0
`define CTD_SP_RST 8'h07

`endif

// *** ctd_pkg.sv ***
// types shared by the control instruction decoder
package ctd_pkg;

    typedef struct packed {
        logic [4:0] op;
        logic [2:0] sub;
        logic [3:0] nib_hi;
        logic [3:0] nib_lo;
    } ctd_fields_t;

    typedef enum logic [3:0] {
        CTD_K_FOREIGN = 4'b0000,
        CTD_K_ALLOW = 4'b0001,
        CTD_K_BLOCK = 4'b0010,
        CTD_K_STOP = 4'b0011,
        CTD_K_HALT = 4'b0100,
        CTD_K_NOP = 4'b0101,
        CTD_K_CALL = 4'b0110,
        CTD_K_JUMP = 4'b0111,
        CTD_K_ILLEGAL = 4'b1000
    } ctd_kind_t;

    typedef enum logic [1:0] {
        CTD_S_RUN = 2'b00,
        CTD_S_STOPPED = 2'b01,
        CTD_S_HALTED = 2'b10
    } ctd_state_t;

    typedef struct packed {
        logic hit;
        logic [1:0] page;
    } ctd_jump_t;

endpackage : ctd_pkg

// *** ctd_classify.sv ***
// splits an instruction word into fields and classifies the control group
`timescale 1ns/1ps
`include "ctd_defs.svh"

module ctd_classify (
    // instruction word
    input wire logic [`CTD_WORD_W-1:0] word,
    // decode result
    output ctd_pkg::ctd_fields_t fields,
    output ctd_pkg::ctd_kind_t kind
);

    always_comb begin
        fields.op = word[`CTD_OP_HI:`CTD_OP_LO];
        fields.sub = word[`CTD_SUB_HI:`CTD_SUB_LO];
        fields.nib_hi = word[`CTD_NH_HI:`CTD_NH_LO];
        fields.nib_lo = word[`CTD_NL_HI:`CTD_NL_LO];
    end

    always_comb begin
        kind = ctd_pkg::CTD_K_FOREIGN;
        if (fields.op == `CTD_OP_CALL) begin
            kind = ctd_pkg::CTD_K_CALL;
        end else if (fields.op[4:2] == 3'(`CTD_OP_JUMP0 >> 2)) begin
            kind = ctd_pkg::CTD_K_JUMP;
        end else if (fields.op == `CTD_OP_CTRL && fields.nib_hi == `CTD_NIB_CTRL) begin
            kind = ctd_pkg::CTD_K_ILLEGAL;
            case (fields.sub)
                `CTD_SUB_ALLOW: begin
                    if (fields.nib_lo == `CTD_NIB_ZERO) kind = ctd_pkg::CTD_K_ALLOW;
                end
                `CTD_SUB_BLOCK: begin
                    if (fields.nib_lo == `CTD_NIB_ZERO) kind = ctd_pkg::CTD_K_BLOCK;
                end
                `CTD_SUB_STOP: begin
                    kind = ctd_pkg::CTD_K_STOP;
                end
                `CTD_SUB_HALT: begin
                    kind = ctd_pkg::CTD_K_HALT;
                end
                `CTD_SUB_NOP: begin
                    if (fields.nib_lo == `CTD_NIB_ZERO) kind = ctd_pkg::CTD_K_NOP;
                end
                default: begin
                    kind = ctd_pkg::CTD_K_ILLEGAL;
                end
            endcase
        end
    end

endmodule : ctd_classify

// *** ctd_page_jump.sv ***
// checks a jump opcode against the number of program pages of the variant
`timescale 1ns/1ps
`include "ctd_defs.svh"

module ctd_page_jump #(
    parameter int NUM_PAGES = 4
) (
    // major opcode
    input wire logic [4:0] op,
    // jump acceptance and page
    output ctd_pkg::ctd_jump_t jump
);

    function automatic ctd_pkg::ctd_jump_t page_of(input logic [4:0] code);
        ctd_pkg::ctd_jump_t res;
        res.hit = 1'b0;
        res.page = `CTD_PAGE_0;
        case (code)
            `CTD_OP_JUMP0: begin
                res.hit = 1'b1;
                res.page = `CTD_PAGE_0;
            end
            `CTD_OP_JUMP1: begin
                res.hit = NUM_PAGES >= 2;
                res.page = `CTD_PAGE_1;
            end
            `CTD_OP_JUMP2: begin
                res.hit = NUM_PAGES >= 3;
                res.page = `CTD_PAGE_2;
            end
            `CTD_OP_JUMP3: begin
                res.hit = NUM_PAGES >= 4;
                res.page = `CTD_PAGE_3;
            end
            default: begin
                res.hit = 1'b0;
            end
        endcase
        // a single-page part has no page select at all
        if (NUM_PAGES < 2) begin
            res.page = `CTD_PAGE_0;
        end
        return res;
    endfunction : page_of

    assign jump = page_of(op);

endmodule : ctd_page_jump

// *** ctd_control_decode.sv ***
// control group instruction decoder with interrupt flag, jump, call and low-power requests
`timescale 1ns/1ps
`include "ctd_defs.svh"

// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
module ctd_control_decode #(
    parameter int NUM_PAGES = 4,
    parameter int PC_W = 13,
    parameter int SP_W = 3
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // instruction word from program memory
    input wire logic [`CTD_WORD_W-1:0] instr_word,
    input wire logic instr_valid,
    output logic instr_ready,
    // core context
    input wire logic [PC_W-1:0] pc_now,
    input wire logic wake_req,
    // interrupt enable
    output logic intr_allow_flag,
    // program counter control
    output logic pc_load,
    output logic [`CTD_ADDR_W-1:0] pc_target,
    output logic [`CTD_PAGE_W-1:0] page_sel,
    output logic pc_advance,
    // subroutine stack
    output logic stack_push,
    output logic [PC_W-1:0] push_data,
    output logic [SP_W-1:0] stack_ptr,
    // low-power requests
    output logic stop_req,
    output logic halt_req,
    output logic [3:0] mode_operand,
    output ctd_pkg::ctd_state_t core_state,
    // decode status
    output logic nop_seen,
    output logic illegal_seen,
    output logic foreign_seen,
    output ctd_pkg::ctd_kind_t last_kind
);

    // ------------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------------
    ctd_pkg::ctd_fields_t fields;
    ctd_pkg::ctd_kind_t kind;
    ctd_pkg::ctd_jump_t jump;
    logic take;
    logic jump_ok;
    logic jump_bad;

    ctd_classify u_classify (
        .word(instr_word),
        .fields(fields),
        .kind(kind)
    );

    ctd_page_jump #(
        .NUM_PAGES(NUM_PAGES)
    ) u_page_jump (
        .op(fields.op),
        .jump(jump)
    );

    ctd_pkg::ctd_state_t state_r;
    ctd_pkg::ctd_state_t state_nxt;

    // words are only taken while the core runs
    assign instr_ready = (state_r == ctd_pkg::CTD_S_RUN);
    assign take = instr_valid && instr_ready;
    assign jump_ok = (kind == ctd_pkg::CTD_K_JUMP) && jump.hit;
    assign jump_bad = (kind == ctd_pkg::CTD_K_JUMP) && !jump.hit;

    // ------------------------------------------------------------------------
    // interrupt enable flag
    // ------------------------------------------------------------------------
    logic intr_r;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            intr_r <= `CTD_INTR_RST;
        end else if (take && kind == ctd_pkg::CTD_K_ALLOW) begin
            intr_r <= 1'b1;
        end else if (take && kind == ctd_pkg::CTD_K_BLOCK) begin
            intr_r <= 1'b0;
        end
    end

    assign intr_allow_flag = intr_r;

    // ------------------------------------------------------------------------
    // program counter load and page select
    // ------------------------------------------------------------------------
    logic load_r;
    logic [`CTD_ADDR_W-1:0] target_r;
    logic [`CTD_PAGE_W-1:0] page_r;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            load_r <= 1'b0;
        end else begin
            load_r <= take && (jump_ok || kind == ctd_pkg::CTD_K_CALL);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            target_r <= '0;
        end else if (take && (jump_ok || kind == ctd_pkg::CTD_K_CALL)) begin
            target_r <= instr_word[`CTD_ADDR_HI:`CTD_ADDR_LO];
        end
    end

    // page select keeps its value between loads
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            page_r <= `CTD_PAGE_RST;
        end else if (take && jump_ok) begin
            page_r <= jump.page;
        end else if (take && kind == ctd_pkg::CTD_K_CALL) begin
            page_r <= `CTD_PAGE_0;
        end
    end

    assign pc_load = load_r;
    assign pc_target = target_r;
    assign page_sel = page_r;

    // ------------------------------------------------------------------------
    // plain advance of the program counter
    // ------------------------------------------------------------------------
    logic adv_r;
    logic adv_nxt;

    always_comb begin
        adv_nxt = 1'b0;
        if (take) begin
            case (kind)
                ctd_pkg::CTD_K_ALLOW: adv_nxt = 1'b1;
                ctd_pkg::CTD_K_BLOCK: adv_nxt = 1'b1;
                ctd_pkg::CTD_K_STOP: adv_nxt = 1'b1;
                ctd_pkg::CTD_K_HALT: adv_nxt = 1'b1;
                ctd_pkg::CTD_K_NOP: adv_nxt = 1'b1;
                default: adv_nxt = 1'b0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            adv_r <= 1'b0;
        end else begin
            adv_r <= adv_nxt;
        end
    end

    assign pc_advance = adv_r;

    // ------------------------------------------------------------------------
    // subroutine stack pointer and push
    // ------------------------------------------------------------------------
    logic push_r;
    logic [PC_W-1:0] push_data_r;
    logic [SP_W-1:0] sp_r;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            push_r <= 1'b0;
        end else begin
            push_r <= take && kind == ctd_pkg::CTD_K_CALL;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            push_data_r <= '0;
        end else if (take && kind == ctd_pkg::CTD_K_CALL) begin
            push_data_r <= pc_now;
        end
    end

    // pointer wraps on overflow; the stack owner guards depth
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sp_r <= SP_W'(`CTD_SP_RST);
        end else if (take && kind == ctd_pkg::CTD_K_CALL) begin
            sp_r <= sp_r - SP_W'(1);
        end
    end

    assign stack_push = push_r;
    assign push_data = push_data_r;
    assign stack_ptr = sp_r;

    // ------------------------------------------------------------------------
    // stop and halt requests
    // ------------------------------------------------------------------------
    logic stop_r;
    logic halt_r;
    logic [3:0] operand_r;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            stop_r <= 1'b0;
            halt_r <= 1'b0;
        end else begin
            stop_r <= take && kind == ctd_pkg::CTD_K_STOP;
            halt_r <= take && kind == ctd_pkg::CTD_K_HALT;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            operand_r <= 4'h0;
        end else if (take && (kind == ctd_pkg::CTD_K_STOP || kind == ctd_pkg::CTD_K_HALT)) begin
            operand_r <= fields.nib_lo;
        end
    end

    assign stop_req = stop_r;
    assign halt_req = halt_r;
    assign mode_operand = operand_r;

    // ------------------------------------------------------------------------
    // core state: fetch is held off while stopped or halted
    // ------------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ctd_pkg::CTD_S_RUN: begin
                if (take && kind == ctd_pkg::CTD_K_STOP) begin
                    state_nxt = ctd_pkg::CTD_S_STOPPED;
                end else if (take && kind == ctd_pkg::CTD_K_HALT) begin
                    state_nxt = ctd_pkg::CTD_S_HALTED;
                end
            end
            ctd_pkg::CTD_S_STOPPED: begin
                if (wake_req) state_nxt = ctd_pkg::CTD_S_RUN;
            end
            ctd_pkg::CTD_S_HALTED: begin
                if (wake_req) state_nxt = ctd_pkg::CTD_S_RUN;
            end
            default: begin
                state_nxt = ctd_pkg::CTD_S_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ctd_pkg::CTD_S_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign core_state = state_r;

    // ------------------------------------------------------------------------
    // decode status
    // ------------------------------------------------------------------------
    logic nop_r;
    logic illegal_r;
    logic foreign_r;
    ctd_pkg::ctd_kind_t kind_r;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            nop_r <= 1'b0;
            illegal_r <= 1'b0;
            foreign_r <= 1'b0;
        end else begin
            nop_r <= take && kind == ctd_pkg::CTD_K_NOP;
            illegal_r <= take && (kind == ctd_pkg::CTD_K_ILLEGAL || jump_bad);
            foreign_r <= take && kind == ctd_pkg::CTD_K_FOREIGN;
        end
    end

    // unsupported jump opcodes report as illegal
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            kind_r <= ctd_pkg::CTD_K_FOREIGN;
        end else if (take) begin
            kind_r <= jump_bad ? ctd_pkg::CTD_K_ILLEGAL : kind;
        end
    end

    assign nop_seen = nop_r;
    assign illegal_seen = illegal_r;
    assign foreign_seen = foreign_r;
    assign last_kind = kind_r;

endmodule : ctd_control_decode

// *** ctd_control_decode_asserts.sv ***
// concurrent checks on the control instruction decoder ports
`timescale 1ns/1ps
module ctd_control_decode_asserts #(
    parameter int NUM_PAGES = 4,
    parameter int PC_W = 13,
    parameter int SP_W = 3
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // instruction port and core context
    input wire logic [15:0] instr_word,
    input wire logic instr_valid,
    input wire logic instr_ready,
    input wire logic [PC_W-1:0] pc_now,
    input wire logic wake_req,
    // decode results
    input wire logic intr_allow_flag,
    input wire logic pc_load,
    input wire logic [10:0] pc_target,
    input wire logic [1:0] page_sel,
    input wire logic pc_advance,
    input wire logic stack_push,
    input wire logic [PC_W-1:0] push_data,
    input wire logic [SP_W-1:0] stack_ptr,
    input wire logic stop_req,
    input wire logic halt_req,
    input wire logic [3:0] mode_operand,
    input wire ctd_pkg::ctd_state_t core_state,
    input wire logic nop_seen,
    input wire logic illegal_seen
);
    logic take;
    logic [4:0] op;
    logic [15:0] word_q;
    assign take = instr_valid && instr_ready;
    assign op = instr_word[15:11];
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            word_q <= 16'h0000;
        end else begin
            word_q <= instr_word;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    a_allow_sets_flag: assert property (take && instr_word == 16'h38f0 |=> intr_allow_flag && pc_advance)
        else $error("allow word did not set the flag");
    a_block_clears_flag: assert property (take && instr_word == 16'h39f0 |=> !intr_allow_flag && pc_advance)
        else $error("block word did not clear the flag");
    a_stop_passes_operand: assert property (take && instr_word[15:4] == 12'h3af |=>
        stop_req && mode_operand == word_q[3:0] && core_state == ctd_pkg::CTD_S_STOPPED)
        else $error("stop word mishandled");
    a_halt_passes_operand: assert property (take && instr_word[15:4] == 12'h3bf |=>
        halt_req && mode_operand == word_q[3:0] && core_state == ctd_pkg::CTD_S_HALTED)
        else $error("halt word mishandled");
    a_nop_changes_nothing: assert property (take && instr_word == 16'h3cf0 |=> nop_seen && pc_advance
        && !pc_load && !stack_push && $stable(intr_allow_flag) && $stable(page_sel))
        else $error("no-op word changed state");
    a_jump_loads_page: assert property (take && op >= 5'h0c
        && op < 5'h0c + NUM_PAGES |=> pc_load && pc_target == word_q[10:0] && page_sel == word_q[12:11])
        else $error("jump target or page wrong");
    a_jump_beyond_pages: assert property (take && op >= 5'h0c + NUM_PAGES && op <= 5'h0f |=> illegal_seen
        && !pc_load && $stable(page_sel))
        else $error("jump beyond last page accepted");
    a_call_pushes_pc: assert property (take && op == 5'h1c |=> stack_push && pc_load && page_sel == 2'h0
        && push_data == $past(pc_now) && stack_ptr == SP_W'($past(stack_ptr) - 1))
        else $error("call push or page wrong");
    a_sleep_refuses_words: assert property (core_state != ctd_pkg::CTD_S_RUN |-> !instr_ready
        ##1 !(pc_load || pc_advance || illegal_seen))
        else $error("word accepted while stopped");
    a_wake_resumes_run: assert property (core_state != ctd_pkg::CTD_S_RUN && wake_req |=>
        core_state == ctd_pkg::CTD_S_RUN && instr_ready)
        else $error("wake did not resume");
    c_call: cover property (take && op == 5'h1c);
    c_stop: cover property (stop_req);
    c_halt: cover property (halt_req);
    c_illegal: cover property (illegal_seen);
endmodule : ctd_control_decode_asserts

bind ctd_control_decode ctd_control_decode_asserts #(.NUM_PAGES(NUM_PAGES), .PC_W(PC_W), .SP_W(SP_W)) u_chk (
    .ref_clk(ref_clk), .resetn(resetn), .instr_word(instr_word), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .pc_now(pc_now), .wake_req(wake_req), .intr_allow_flag(intr_allow_flag),
    .pc_load(pc_load), .pc_target(pc_target), .page_sel(page_sel), .pc_advance(pc_advance),
    .stack_push(stack_push), .push_data(push_data), .stack_ptr(stack_ptr), .stop_req(stop_req),
    .halt_req(halt_req), .mode_operand(mode_operand), .core_state(core_state), .nop_seen(nop_seen),
    .illegal_seen(illegal_seen));

// *** ctd_prog_mem.sv ***
// program memory model that offers instruction words to the decoder
`timescale 1ns/1ps
module ctd_prog_mem (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // word requested by the bench
    input wire logic [15:0] feed_word,
    input wire logic feed_valid,
    // instruction port
    input wire logic instr_ready,
    output logic [15:0] instr_word,
    output logic instr_valid
);
    logic [15:0] last_r;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            last_r <= 16'h0000;
        end else if (feed_valid && instr_ready) begin
            last_r <= feed_word;
        end
    end
    // an idle bus shows the inverse of the last taken word, never a stale copy
    assign instr_valid = feed_valid;
    assign instr_word = feed_valid ? feed_word : ~last_r;
endmodule : ctd_prog_mem

// *** test_control_instr_decode.sv ***
// self-checking bench for the control instruction decoder
`timescale 1ns/1ps
module test_control_instr_decode;
    typedef struct packed {
        logic [3:0] kind;
        logic flag;
        logic [7:0] pulses;
        logic [12:0] jmp;
        logic [5:0] lowp;
        logic [15:0] stk;
    } ctd_tb_exp_t;
    logic ref_clk = 1'b0, resetn = 1'b0, feed_valid = 1'b0, wake_req = 1'b0, instr_valid, instr_ready;
    logic [15:0] feed_word = 16'h0000, instr_word;
    logic [12:0] pc_now = 13'h0000, push_data;
    logic intr_allow_flag, pc_load, pc_advance, stack_push, stop_req, halt_req, nop_seen, illegal_seen, foreign_seen;
    logic [10:0] pc_target, t4;
    logic [1:0] page_sel, p4, p1;
    logic [2:0] stack_ptr;
    logic [3:0] mode_operand;
    ctd_pkg::ctd_state_t core_state;
    ctd_pkg::ctd_kind_t last_kind;
    ctd_tb_exp_t exp_q[$];
    ctd_tb_exp_t mon_e;
    int err_count = 0, checked = 0, cyc = 0, i;
    integer seed = 32'hd340_efcd;
    logic m_flag, il1;
    logic [1:0] m_page;
    logic [10:0] m_tgt;
    logic [3:0] m_op;
    logic [2:0] m_sp;
    logic [12:0] m_push;
    logic [15:0] dir_tab[18] = '{16'h38f0, 16'h39f0, 16'h38f0, 16'h3af5, 16'h3bfa, 16'h3cf0, 16'h6123, 16'h6923,
        16'h7123, 16'h7923, 16'he123, 16'he456, 16'h38f1, 16'h3df0, 16'h3ff0, 16'h38e0, 16'h1234, 16'h39f0};

    always #20 ref_clk = ~ref_clk;

    ctd_prog_mem u_mem (.ref_clk(ref_clk), .resetn(resetn), .feed_word(feed_word), .feed_valid(feed_valid),
        .instr_ready(instr_ready), .instr_word(instr_word), .instr_valid(instr_valid));
    ctd_control_decode #(.NUM_PAGES(3)) dut (.ref_clk(ref_clk), .resetn(resetn), .instr_word(instr_word),
        .instr_valid(instr_valid), .instr_ready(instr_ready), .pc_now(pc_now), .wake_req(wake_req),
        .intr_allow_flag(intr_allow_flag), .pc_load(pc_load), .pc_target(pc_target), .page_sel(page_sel),
        .pc_advance(pc_advance), .stack_push(stack_push), .push_data(push_data), .stack_ptr(stack_ptr),
        .stop_req(stop_req), .halt_req(halt_req), .mode_operand(mode_operand), .core_state(core_state),
        .nop_seen(nop_seen), .illegal_seen(illegal_seen), .foreign_seen(foreign_seen), .last_kind(last_kind));
    // four-page variant fed the same words
    ctd_control_decode #(.NUM_PAGES(4)) dut4 (.ref_clk(ref_clk), .resetn(resetn), .instr_word(instr_word),
        .instr_valid(instr_valid), .instr_ready(), .pc_now(pc_now), .wake_req(wake_req), .intr_allow_flag(),
        .pc_load(), .pc_target(t4), .page_sel(p4), .pc_advance(), .stack_push(), .push_data(), .stack_ptr(),
        .stop_req(), .halt_req(), .mode_operand(), .core_state(), .nop_seen(), .illegal_seen(), .foreign_seen(),
        .last_kind());
    ctd_control_decode #(.NUM_PAGES(1)) dut1 (.ref_clk(ref_clk), .resetn(resetn), .instr_word(instr_word),
        .instr_valid(instr_valid), .instr_ready(), .pc_now(pc_now), .wake_req(wake_req), .intr_allow_flag(),
        .pc_load(), .pc_target(), .page_sel(p1), .pc_advance(), .stack_push(), .push_data(), .stack_ptr(),
        .stop_req(), .halt_req(), .mode_operand(), .core_state(), .nop_seen(), .illegal_seen(il1), .foreign_seen(),
        .last_kind());

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    function automatic ctd_pkg::ctd_kind_t kind_of(input logic [15:0] w);
        if (w[15:11] == 5'h07 && w[7:4] == 4'hf) begin
            case (w[10:8])
                3'h0: return (w[3:0] == 4'h0) ? ctd_pkg::CTD_K_ALLOW : ctd_pkg::CTD_K_ILLEGAL;
                3'h1: return (w[3:0] == 4'h0) ? ctd_pkg::CTD_K_BLOCK : ctd_pkg::CTD_K_ILLEGAL;
                3'h2: return ctd_pkg::CTD_K_STOP;
                3'h3: return ctd_pkg::CTD_K_HALT;
                3'h4: return (w[3:0] == 4'h0) ? ctd_pkg::CTD_K_NOP : ctd_pkg::CTD_K_ILLEGAL;
                default: return ctd_pkg::CTD_K_ILLEGAL;
            endcase
        end
        if (w[15:11] >= 5'h0c && w[15:11] <= 5'h0e) return ctd_pkg::CTD_K_JUMP;
        if (w[15:11] == 5'h0f) return ctd_pkg::CTD_K_ILLEGAL;
        if (w[15:11] == 5'h1c) return ctd_pkg::CTD_K_CALL;
        return ctd_pkg::CTD_K_FOREIGN;
    endfunction : kind_of

    task automatic do_reset;
        resetn = 1'b0;
        repeat (8) @(negedge ref_clk);
        resetn = 1'b1;
        {m_flag, m_page, m_tgt, m_op, m_sp, m_push} = {1'b0, 2'h0, 11'h000, 4'h0, 3'h7, 13'h0000};
        @(negedge ref_clk);
        check("reset", {intr_allow_flag, instr_ready, page_sel, stack_ptr, mode_operand, core_state, last_kind},
            {1'b0, 1'b1, 2'h0, 3'h7, 4'h0, 2'h0, 4'h0});
    endtask : do_reset

    // offers one word, notes its expected effect and handles wake-up after stop or halt
    task automatic send(input logic [15:0] w);
        ctd_tb_exp_t e;
        logic [7:0] p;
        logic [1:0] st;
        e.kind = kind_of(w);
        st = 2'h0;
        pc_now = 13'($random(seed));
        case (e.kind)
            ctd_pkg::CTD_K_ALLOW: {m_flag, p} = {1'b1, 8'h40};
            ctd_pkg::CTD_K_BLOCK: {m_flag, p} = {1'b0, 8'h40};
            ctd_pkg::CTD_K_STOP: {m_op, st, p} = {w[3:0], 2'h1, 8'h50};
            ctd_pkg::CTD_K_HALT: {m_op, st, p} = {w[3:0], 2'h2, 8'h48};
            ctd_pkg::CTD_K_NOP: p = 8'h44;
            ctd_pkg::CTD_K_JUMP: {m_tgt, m_page, p} = {w[10:0], w[12:11], 8'h80};
            ctd_pkg::CTD_K_CALL: {m_tgt, m_page, m_sp, m_push, p} = {w[10:0], 2'h0, m_sp - 3'h1, pc_now, 8'ha0};
            ctd_pkg::CTD_K_ILLEGAL: p = 8'h02;
            default: p = 8'h01;
        endcase
        e.flag = m_flag;
        e.pulses = p;
        e.jmp = {m_page, m_tgt};
        e.lowp = {m_op, st};
        e.stk = {m_sp, m_push};
        exp_q.push_back(e);
        feed_word = w;
        feed_valid = 1'b1;
        @(negedge ref_clk);
        if (w[15:11] == 5'h0f) check("page4", {p4, t4}, {2'h3, w[10:0]});
        if (w[15:13] == 3'b011) check("page1", {il1, p1}, {w[12:11] != 2'h0, 2'h0});
        if (st != 2'h0) begin
            feed_word = 16'h38f0;
            repeat (3) begin
                check("ready", instr_ready, 1'b0);
                @(negedge ref_clk);
            end
            feed_valid = 1'b0;
            wake_req = 1'b1;
            @(negedge ref_clk);
            wake_req = 1'b0;
            check("wake", {core_state, instr_ready}, {2'h0, 1'b1});
        end
    endtask : send

    always @(negedge ref_clk) begin
        if (resetn && (pc_load || pc_advance || illegal_seen || foreign_seen)) begin
            check("result_expected", exp_q.size() != 0, 1);
            if (exp_q.size() != 0) begin
                mon_e = exp_q.pop_front();
                check("kind", last_kind, mon_e.kind);
                check("flag", intr_allow_flag, mon_e.flag);
                check("pulses", {pc_load, pc_advance, stack_push, stop_req, halt_req, nop_seen, illegal_seen,
                    foreign_seen}, mon_e.pulses);
                check("jump", {page_sel, pc_target}, mon_e.jmp);
                check("lowpower", {mode_operand, core_state}, mon_e.lowp);
                check("stack", {stack_ptr, push_data}, mon_e.stk);
            end
        end
    end

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            report_and_stop();
        end
    end

    initial begin
        logic [31:0] r;
        logic [15:0] w;
        do_reset();
        foreach (dir_tab[k]) send(dir_tab[k]);
        feed_valid = 1'b0;
        repeat (2) @(negedge ref_clk);
        $display("test directed done");
        for (i = 0; i < 150; i++) begin
            r = $random(seed);
            w = r[15:0];
            if (r[20]) {w[15:11], w[7:4]} = {5'h07, 4'hf};
            if (r[21] && r[22]) w[3:0] = 4'h0;
            if (r[23] && !r[20]) w[15:13] = 3'b011;
            send(w);
        end
        feed_valid = 1'b0;
        repeat (2) @(negedge ref_clk);
        $display("test random done");
        do_reset();
        send(16'he7ff);
        send(16'h38f0);
        feed_valid = 1'b0;
        repeat (2) @(negedge ref_clk);
        $display("test second reset done");
        report_and_stop();
    end
endmodule : test_control_instr_decode
